/* File: verilog/ecp_defines.vh */
// Purpose: Shared constants of the two-wire serial memory client.
// Assumes: One 200 MHz system clock samples the bus pins.
// Notes: Times are kept in their own units; cycle counts derive from them.
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH

// Control byte layout
`define ECP_CTRL_CODE 4'hA
`define ECP_CODE_HI 7
`define ECP_CODE_LO 4
`define ECP_BLK_HI_BIT 2
`define ECP_BLK_LO_BIT 1
`define ECP_RW_BIT 0
`define ECP_RW_READ 1'h1

// Memory shape: four blocks of 256 bytes, 16-byte pages
`define ECP_ADDR_W 10
`define ECP_PAGE_W 4
`define ECP_PAGE_SIZE 16
`define ECP_PAGE_LAST 4'hF
`define ECP_BYTE_DONE 4'h8

// Timing
`define ECP_CLK_NS 5
`define ECP_CLK_MHZ 200
`define ECP_TSP_NS 50
`define ECP_TWC_MS 5
// Spike width rounded up to whole cycles
`define ECP_SPIKE_CYC ((`ECP_TSP_NS + `ECP_CLK_NS - 1) / `ECP_CLK_NS)
// Longest write cycle in whole cycles; the product needs no rounding
`define ECP_TWC_CYC (`ECP_TWC_MS * `ECP_CLK_MHZ * 1000)
`define ECP_TWC_W 20

// Write path buffer
`define ECP_FIFO_DEPTH 4
`define ECP_FIFO_AW 2

`endif

/* File: verilog/ecp_glitch_filter.v */
// Purpose: Synchronise one bus pin and suppress short spikes on it.
// Assumes: The pin is asynchronous to clk_in.
// Notes: A new level passes only after CNT consecutive equal samples.
`timescale 1ns/1ps
`default_nettype none
module ecp_glitch_filter #(
  parameter CNT = 10
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Pin and filtered level
  input wire raw_in,
  output wire filt_out
);
  localparam [7:0] CNT_M1 = CNT - 1;
  reg sync1_ff; // First stage, read only by the second
  reg sync2_ff; // Second stage, safe to use
  reg filt_ff; // Filtered level
  reg [7:0] cnt_ff; // Samples that disagree with filt_ff

  // Idle bus level is high, so both sync stages and the filtered level reset high
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 1'h1;
      sync2_ff <= 1'h1;
      filt_ff <= 1'h1;
      cnt_ff <= 8'h00;
    end else if (ce_in) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      if (sync2_ff == filt_ff) begin
        // Spike ended before it was long enough
        cnt_ff <= 8'h00;
      end else if (cnt_ff == CNT_M1) begin
        filt_ff <= sync2_ff;
        cnt_ff <= 8'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign filt_out = filt_ff;
endmodule
`default_nettype wire

/* File: verilog/ecp_fifo.v */
// Purpose: Small valid/ready FIFO held in flip-flops.
// Assumes: D is a power of two and AW is its log2.
// Notes: Full and empty use an extra pointer wrap bit.
`timescale 1ns/1ps
`default_nettype none
module ecp_fifo #(
  parameter W = 18,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_ff [0:D-1]; // Storage
  reg [AW:0] wr_ptr_ff; // Write pointer with wrap bit
  reg [AW:0] rd_ptr_ff; // Read pointer with wrap bit
  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
    (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;

  // Storage needs no reset; only the pointers are control state
  always @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
    end
  end

  // Pointer update
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];
endmodule
`default_nettype wire

/* File: verilog/ecp_client.v */
// Purpose: Client side of a two-wire serial memory bus, 1 KB array.
// Assumes: Array sits outside; reads within 2 cycles of the address.
// Notes: Pins are sampled by mclk_in; the array is written via a FIFO.
// Behaviour
// - Data line stable while clock high
// - Falling data, clock high, is Start
// - Rising data, clock high, is Stop
// - Receiver pulls data low on ninth pulse
// - No acknowledge during internal write cycle
// - Host not-acknowledge ends read; release line
// - Control byte: code 1010, ignored, block, rw
// - Block bits are top address bits
// - Last control bit one reads, zero writes
// - Acknowledge matching control byte, choose direction
// - Next write byte loads word address
// - Stop after write starts internal cycle
// - Up to 16 bytes buffered until Stop
// - Write increments only low four bits
// - Extra bytes overwrite oldest, last sixteen kept
// - Protect input high blocks all writes
// - Busy device ignores polling, acknowledges after
// - Pointer holds last address plus one
// - Repeated Start keeps newly written pointer
// - Acknowledged read increments pointer, sends next
// - Filter spikes on clock and data
// - Write cycle ends within five milliseconds; a stalled array stretches it beyond that
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defines.vh"
module ecp_client #(
  parameter SPIKE_CYC = `ECP_SPIKE_CYC,
  parameter TWC_CYC = `ECP_TWC_CYC
) (
  // Clock, reset, enable
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  // Write-protect strap
  input wire wp_in,
  // Array read port
  output wire [`ECP_ADDR_W-1:0] mem_rd_addr_out,
  input wire [7:0] mem_rd_data_in,
  // Array write port
  output wire mem_wr_valid_out,
  input wire mem_wr_ready_in,
  output wire [`ECP_ADDR_W-1:0] mem_wr_addr_out,
  output wire [7:0] mem_wr_data_out,
  // Status
  output wire busy_out
);
  // One-hot protocol states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CTRL = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_WDATA = 6'h08;
  localparam [5:0] ST_RDATA = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;
  localparam [`ECP_TWC_W-1:0] TWC_LAST = TWC_CYC - 1;
  localparam FW = `ECP_ADDR_W + 8; // FIFO word: address and data

  wire scl_f; // Filtered clock level
  wire sda_f; // Filtered data level
  reg scl_d_ff; // Clock level one cycle ago
  reg sda_d_ff; // Data level one cycle ago
  reg wp_s1_ff; // Protect strap, first sync stage
  reg wp_s2_ff; // Protect strap, usable
  reg [5:0] state_ff; // Protocol state
  reg [3:0] bit_cnt_ff; // Clock rises seen in this byte
  reg [7:0] rx_ff; // Shift register of received bits
  reg [7:0] tx_ff; // Bits still to send
  reg [`ECP_ADDR_W-1:0] ptr_ff; // Address pointer
  reg sda_oe_ff; // Pulling the data line low
  reg sda_lvl_ff; // Open drain only ever drives zero
  reg own_ack_ff; // Our acknowledge is on the line
  reg [7:0] page_ff [0:`ECP_PAGE_SIZE-1]; // Page buffer
  reg [`ECP_PAGE_SIZE-1:0] page_vld_ff; // Bytes to commit
  reg commit_go_ff; // Pulse: Stop ended a write
  reg busy_ff; // Internal write cycle running
  reg cact_ff; // Page being pushed into the FIFO
  reg [`ECP_PAGE_W-1:0] cidx_ff; // Page slot being pushed
  reg [`ECP_TWC_W-1:0] twc_ff; // Write cycle timer
  reg wr_valid_ff; // Array write request held
  reg [`ECP_ADDR_W-1:0] wr_addr_ff; // Array write address
  reg [7:0] wr_data_ff; // Array write data
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire fifo_out_ready = !wr_valid_ff || mem_wr_ready_in;
  wire cur_vld = page_vld_ff[cidx_ff];
  wire push = cact_ff && cur_vld;

  // Bus conditions seen on the filtered levels
  wire scl_rise = scl_f && !scl_d_ff;
  wire scl_fall = !scl_f && scl_d_ff;
  wire start_det = scl_f && scl_d_ff &&
    sda_d_ff && !sda_f;
  wire stop_det = scl_f && scl_d_ff &&
    !sda_d_ff && sda_f;
  wire code_ok = rx_ff[`ECP_CODE_HI:`ECP_CODE_LO] == `ECP_CTRL_CODE;
  wire byte_full = bit_cnt_ff == `ECP_BYTE_DONE;

  // Both pins pass two flops and a spike filter before decoding
  ecp_glitch_filter #(
    .CNT(SPIKE_CYC)
  ) u_scl_filt (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .raw_in(scl_in),
    .filt_out(scl_f)
  );

  ecp_glitch_filter #(
    .CNT(SPIKE_CYC)
  ) u_sda_filt (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .raw_in(sda_in),
    .filt_out(sda_f)
  );

  // Edge history and protect strap sync
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
      wp_s1_ff <= 1'h1;
      wp_s2_ff <= 1'h1;
    end else if (ce_in) begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
      wp_s1_ff <= wp_in;
      wp_s2_ff <= wp_s1_ff;
    end
  end

  // Page buffer storage; writes land at the pointer's low bits
  always @(posedge mclk_in) begin
    if (ce_in && scl_fall && byte_full && !own_ack_ff &&
        state_ff == ST_WDATA) begin
      page_ff[ptr_ff[`ECP_PAGE_W-1:0]] <= rx_ff;
    end
  end

  // Protocol engine. The line only changes on a clock fall, so
  // our own drive can never look like Start or Stop to the host.
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= {`ECP_ADDR_W{1'b0}};
      sda_oe_ff <= 1'h0;
      sda_lvl_ff <= 1'h0;
      own_ack_ff <= 1'h0;
      page_vld_ff <= {`ECP_PAGE_SIZE{1'b0}};
      commit_go_ff <= 1'h0;
    end else if (ce_in) begin
      commit_go_ff <= 1'h0;
      if (start_det) begin
        // Start wins in any state, also as a repeated Start;
        // the pointer is kept for a following read
        state_ff <= ST_CTRL;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'h0;
        own_ack_ff <= 1'h0;
      end else if (stop_det) begin
        // Stop ends the transaction and commits buffered bytes
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'h0;
        own_ack_ff <= 1'h0;
        if (state_ff == ST_WDATA && |page_vld_ff) begin
          commit_go_ff <= 1'h1;
        end
      end else if (scl_rise) begin
        // Sample on the rising clock; data is stable while high
        if (!byte_full) begin
          rx_ff <= {rx_ff[6:0], sda_f};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else begin
          // Ninth pulse: acknowledge bit
          bit_cnt_ff <= 4'h0;
          if (!own_ack_ff && state_ff == ST_RDATA) begin
            // Byte sent counts as accessed
            ptr_ff <= ptr_ff + 10'h001;
            if (sda_f) begin
              // Host left the line high: stop sending
              state_ff <= ST_IGNORE;
            end
          end
        end
      end else if (scl_fall) begin
        if (byte_full) begin
          // Eight bits are in: decide our answer
          case (state_ff)
            ST_CTRL: begin
              if (code_ok && !busy_ff) begin
                // Matching client address: acknowledge
                sda_oe_ff <= 1'h1;
                own_ack_ff <= 1'h1;
                ptr_ff[`ECP_ADDR_W-1] <= rx_ff[`ECP_BLK_HI_BIT];
                ptr_ff[`ECP_ADDR_W-2] <= rx_ff[`ECP_BLK_LO_BIT];
                if (rx_ff[`ECP_RW_BIT] == `ECP_RW_READ) begin
                  state_ff <= ST_RDATA;
                end else begin
                  state_ff <= ST_ADDR;
                  page_vld_ff <= {`ECP_PAGE_SIZE{1'b0}};
                end
              end else begin
                // Wrong code, or busy writing: stay silent
                state_ff <= ST_IGNORE;
              end
            end
            ST_ADDR: begin
              // Word address within the selected block
              ptr_ff[7:0] <= rx_ff;
              sda_oe_ff <= 1'h1;
              own_ack_ff <= 1'h1;
              state_ff <= ST_WDATA;
            end
            ST_WDATA: begin
              // Protected bytes are acknowledged but never kept
              if (!wp_s2_ff) begin
                page_vld_ff[ptr_ff[`ECP_PAGE_W-1:0]] <= 1'h1;
              end
              // Only the page offset moves, so the page wraps
              ptr_ff[`ECP_PAGE_W-1:0] <=
                ptr_ff[`ECP_PAGE_W-1:0] + 4'h1;
              sda_oe_ff <= 1'h1;
              own_ack_ff <= 1'h1;
            end
            ST_RDATA: begin
              // Let go so the host can answer
              sda_oe_ff <= 1'h0;
            end
            default: begin
              sda_oe_ff <= 1'h0;
            end
          endcase
        end else if (state_ff == ST_RDATA) begin
          if (bit_cnt_ff == 4'h0) begin
            // New byte: take array data at the pointer
            tx_ff <= {mem_rd_data_in[6:0], 1'b0};
            sda_oe_ff <= !mem_rd_data_in[7];
          end else begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            sda_oe_ff <= !tx_ff[7];
          end
          own_ack_ff <= 1'h0;
        end else if (own_ack_ff) begin
          // End of our acknowledge pulse
          sda_oe_ff <= 1'h0;
          own_ack_ff <= 1'h0;
        end else begin
          sda_oe_ff <= 1'h0;
        end
      end
    end
  end

  // Internal write cycle: push the page into the FIFO while holding
  // busy for the full cycle time. A stalled array delays the end
  // beyond that time, which is the price of honest back-pressure.
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      busy_ff <= 1'h0;
      cact_ff <= 1'h0;
      cidx_ff <= {`ECP_PAGE_W{1'b0}};
      twc_ff <= {`ECP_TWC_W{1'b0}};
    end else if (ce_in) begin
      if (commit_go_ff) begin
        busy_ff <= 1'h1;
        cact_ff <= 1'h1;
        cidx_ff <= {`ECP_PAGE_W{1'b0}};
        twc_ff <= {`ECP_TWC_W{1'b0}};
      end else if (busy_ff) begin
        if (twc_ff != TWC_LAST) begin
          twc_ff <= twc_ff + 20'h00001;
        end
        if (cact_ff && (!cur_vld || fifo_in_ready)) begin
          // Skip empty slots, wait when the FIFO is full
          cidx_ff <= cidx_ff + 4'h1;
          if (cidx_ff == `ECP_PAGE_LAST) begin
            cact_ff <= 1'h0;
          end
        end
        if (twc_ff == TWC_LAST && !cact_ff &&
            !fifo_out_valid && !wr_valid_ff) begin
          // Polling is acknowledged again from here
          busy_ff <= 1'h0;
        end
      end
    end
  end

  ecp_fifo #(
    .W(FW),
    .D(`ECP_FIFO_DEPTH),
    .AW(`ECP_FIFO_AW)
  ) u_wr_fifo (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({ptr_ff[`ECP_ADDR_W-1:`ECP_PAGE_W], cidx_ff,
      page_ff[cidx_ff]}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // Array write request register, refilled when free or taken
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wr_valid_ff <= 1'h0;
      wr_addr_ff <= {`ECP_ADDR_W{1'b0}};
      wr_data_ff <= 8'h00;
    end else if (ce_in && fifo_out_ready) begin
      wr_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        wr_addr_ff <= fifo_out_data[FW-1:8];
        wr_data_ff <= fifo_out_data[7:0];
      end
    end
  end

  // Outputs straight from flip-flops
  assign sda_out = sda_lvl_ff;
  assign sda_oe_out = sda_oe_ff;
  assign mem_rd_addr_out = ptr_ff;
  assign mem_wr_valid_out = wr_valid_ff;
  assign mem_wr_addr_out = wr_addr_ff;
  assign mem_wr_data_out = wr_data_ff;
  assign busy_out = busy_ff;
endmodule
`default_nettype wire

/* File: verif/ecp_client_asserts.sv */
// Purpose: Concurrent checks on the ports of the serial memory client.
// Assumes: Bus clock period near 48 ns, well above pin-to-logic latency.
// Notes: The write-cycle bound counts only cycles with the array ready.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defines.vh"
module ecp_client_asserts #(
  parameter TWC_CYC = 64
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Bus pins and strap
  input wire scl_in,
  input wire sda_oe_out,
  input wire wp_in,
  // Array write port and status
  input wire mem_wr_valid_out,
  input wire mem_wr_ready_in,
  input wire [`ECP_ADDR_W-1:0] mem_wr_addr_out,
  input wire [7:0] mem_wr_data_out,
  input wire busy_out
);
  // Busy cycles seen while the array could take writes
  reg [31:0] busy_cnt_ff;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // A stalled array may stretch busy, so stalled cycles are not counted
  always @(posedge mclk_in) begin
    if (!rst_n_in || !busy_out) busy_cnt_ff <= 32'h0;
    else if (mem_wr_ready_in) busy_cnt_ff <= busy_cnt_ff + 32'h1;
  end
  oe_change_low_a: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 3))
    else $error("data drive moved outside clock low");
  busy_no_ack_a: assert property (busy_out |-> !$rose(sda_oe_out))
    else $error("drive started during write cycle");
  ack_width_a: assert property ($rose(sda_oe_out) |=> sda_oe_out [*7])
    else $error("low drive shorter than a bit");
  wp_blocks_a: assert property (wp_in && $past(wp_in, 8) |-> !mem_wr_valid_out)
    else $error("array write while protected");
  wr_hold_a: assert property (mem_wr_valid_out && !mem_wr_ready_in |=>
    mem_wr_valid_out && $stable(mem_wr_addr_out) && $stable(mem_wr_data_out))
    else $error("write request dropped or changed");
  wr_in_page_a: assert property (mem_wr_valid_out && mem_wr_ready_in ##1
    mem_wr_valid_out |-> mem_wr_addr_out[9:4] == $past(mem_wr_addr_out[9:4])
    && mem_wr_addr_out[3:0] > $past(mem_wr_addr_out[3:0]))
    else $error("page write left its page");
  busy_bound_a: assert property (busy_cnt_ff <= TWC_CYC + 32)
    else $error("write cycle too long");
  busy_after_stop_a: assert property ($rose(busy_out) |->
    scl_in && $past(scl_in, 8))
    else $error("write cycle began without stop");
endmodule
bind ecp_client ecp_client_asserts #(.TWC_CYC(TWC_CYC)) i_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
  .sda_oe_out(sda_oe_out), .wp_in(wp_in), .busy_out(busy_out),
  .mem_wr_valid_out(mem_wr_valid_out), .mem_wr_ready_in(mem_wr_ready_in),
  .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out));
`default_nettype wire

/* File: verif/ecp_host_model.sv */
// Purpose: Behavioural bus host that clocks the serial memory client.
// Assumes: Open-drain data wire with pull-up, resolved by the bench.
// Notes: Clock period 48 ns; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module ecp_host_model (
  // Wire level seen on the bus
  input wire logic sda_in,
  // Driven pins, data one means released
  output logic scl_out,
  output logic sda_rel_out
);
  localparam int QTR = 12; // Quarter of the bus clock period, ns
  initial begin
    scl_out = 1'b1; // Idle bus, both lines high
    sda_rel_out = 1'b1;
  end
  // Start, also repeated; data rises early so no Stop is seen
  task start;
    sda_rel_out <= 1'b1;
    #(2*QTR) scl_out <= 1'b1;
    #(2*QTR) sda_rel_out <= 1'b0;
    #(2*QTR) scl_out <= 1'b0;
    #QTR;
  endtask
  // Stop; clock then stands high
  task stop;
    sda_rel_out <= 1'b0;
    #(2*QTR) scl_out <= 1'b1;
    #(2*QTR) sda_rel_out <= 1'b1;
    #(4*QTR);
  endtask
  // One pulse per bit; data moves only while clock is low
  // Long low phase: the client's filtered drive settles before the rise
  task xbit(input logic b, output logic r);
    sda_rel_out <= b;
    #(2*QTR) scl_out <= 1'b1;
    #(QTR-1) r = sda_in;
    #1 scl_out <= 1'b0;
    #QTR;
  endtask
  // Byte out MSB first, ninth pulse for the acknowledge
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  // Byte in; a released ninth bit ends the read
  task rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!more, r);
  endtask
  // A one bit with a narrow low spike on data while the clock is high
  task spike;
    sda_rel_out <= 1'b1;
    #(2*QTR) scl_out <= 1'b1;
    #(QTR/2) sda_rel_out <= 1'b0;
    #2 sda_rel_out <= 1'b1;
    #(QTR/2-2) scl_out <= 1'b0;
    #QTR;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the serial memory client.
// Assumes: Array model answers a read one cycle after the address.
// Notes: Spike and write-cycle counts are shrunk to keep the run short.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defines.vh"
module testbench;
  localparam int TWC = 400; // Long enough to poll while busy
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wp_in = 1'b0;
  logic stall = 1'b0; // Holds off the array write port
  logic mem_wr_ready_in = 1'b1;
  logic [7:0] mem_rd_data_in = 8'h00;
  wire scl, sda_rel, sda_oe_out, busy_out, mem_wr_valid_out, sda_lvl;
  wire [`ECP_ADDR_W-1:0] mem_rd_addr_out, mem_wr_addr_out;
  wire [7:0] mem_wr_data_out;
  // Pull-up; a driving client puts its drive level on the wire
  wire sda = sda_rel & (sda_lvl | !sda_oe_out);
  logic [7:0] mem [0:1023]; // Array contents
  logic [7:0] exp_mem [0:1023]; // Expected contents
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic ack;
  logic [7:0] rd;
  always #2.5 mclk_in = !mclk_in;
  // Array model; ready is registered from the stall flag
  always @(posedge mclk_in) begin
    mem_rd_data_in <= mem[mem_rd_addr_out];
    mem_wr_ready_in <= !stall;
    if (mem_wr_valid_out && mem_wr_ready_in)
      mem[mem_wr_addr_out] <= mem_wr_data_out;
  end
  // Hang guard
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      summarize();
    end
  end
  ecp_client #(.SPIKE_CYC(2), .TWC_CYC(TWC)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_lvl), .sda_oe_out(sda_oe_out), .wp_in(wp_in),
    .mem_rd_addr_out(mem_rd_addr_out), .mem_rd_data_in(mem_rd_data_in),
    .mem_wr_valid_out(mem_wr_valid_out), .mem_wr_ready_in(mem_wr_ready_in),
    .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
    .busy_out(busy_out));
  ecp_host_model i_host (.sda_in(sda), .scl_out(scl), .sda_rel_out(sda_rel));
  task chk(input string what, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task summarize;
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the write cycle and its array writes to end
  task wait_idle;
    int n;
    n = 0;
    while ((busy_out !== 1'b0 || mem_wr_valid_out !== 1'b0) && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    chk("write cycle length", 1'b1, n <= TWC + 40);
  endtask
  // Control, word address, then n bytes counting up from sd
  task write_page(input logic [9:0] a, input int n, input logic [7:0] sd);
    i_host.start();
    i_host.wbyte({4'hA, 1'b0, a[9:8], 1'b0}, ack);
    chk("control ack", 1'b1, ack);
    i_host.wbyte(a[7:0], ack);
    chk("address ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      i_host.wbyte(sd + 8'(i), ack);
      chk("data ack", 1'b1, ack);
    end
    chk("commit before stop", 1'b0, mem_wr_valid_out);
    i_host.stop();
  endtask
  // Byte write, poll while busy, poll again once done
  task test_byte_poll;
    write_page(10'h235, 1, 8'hA5);
    exp_mem[10'h235] = 8'hA5;
    chk("busy after stop", 1'b1, busy_out);
    i_host.start();
    i_host.wbyte(8'hA0, ack);
    chk("poll while busy", 1'b0, ack);
    i_host.stop();
    wait_idle();
    i_host.start();
    i_host.wbyte(8'hA0, ack);
    chk("poll after cycle", 1'b1, ack);
    i_host.stop();
    chk("written byte", exp_mem[10'h235], mem[10'h235]);
  endtask
  // Stalled array; 18 bytes wrap inside one page, last 16 kept
  task test_page;
    @(posedge mclk_in) stall <= 1'b1;
    write_page(10'h1F4, 18, 8'h40);
    for (int i = 0; i < 18; i++) exp_mem[{6'h1F, 4'(4 + i)}] = 8'h40 + 8'(i);
    repeat (60) @(posedge mclk_in);
    chk("held write request", 1'b1, mem_wr_valid_out);
    @(posedge mclk_in) stall <= 1'b0;
    wait_idle();
    for (int i = 0; i < 16; i++)
      chk("page slot", exp_mem[10'h1F0 + i], mem[10'h1F0 + i]);
  endtask
  // Protected write is answered but changes nothing; strap stays high
  task test_protect;
    @(posedge mclk_in) wp_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    write_page(10'h010, 1, 8'hC3);
    wait_idle();
    chk("protected byte", exp_mem[10'h010], mem[10'h010]);
  endtask
  // Random read across a block edge, then a current address read
  task test_read;
    i_host.start();
    i_host.wbyte(8'hA2, ack);
    i_host.wbyte(8'hFE, ack);
    i_host.start();
    i_host.wbyte(8'hA3, ack);
    chk("read control ack", 1'b1, ack);
    for (int i = 0; i < 3; i++) begin
      i_host.rbyte(i < 2, rd);
      chk("sequential byte", exp_mem[10'h1FE + i], rd);
    end
    i_host.stop();
    chk("line released", 1'b0, sda_oe_out);
    i_host.start();
    i_host.wbyte(8'hA5, ack);
    i_host.rbyte(1'b0, rd);
    i_host.stop();
    chk("current address byte", exp_mem[10'h201], rd);
    @(posedge mclk_in) wp_in <= 1'b0;
  endtask
  // Foreign code, then a later byte in the same frame
  task test_bad_code;
    i_host.start();
    i_host.wbyte(8'hB0, ack);
    chk("foreign code ack", 1'b0, ack);
    i_host.wbyte(8'hA0, ack);
    chk("ignored byte ack", 1'b0, ack);
    i_host.stop();
  endtask
  // Data spike inside a byte must not pass for Start and Stop
  task test_spike;
    logic [7:0] d;
    d = 8'hB6;
    i_host.start();
    i_host.wbyte(8'hA0, ack);
    i_host.wbyte(8'h33, ack);
    i_host.spike(); // Bit 7, a one, with a glitch while clock high
    for (int i = 6; i >= 0; i--) i_host.xbit(d[i], ack);
    i_host.xbit(1'b1, ack); // Raw line: low means acknowledged
    chk("ack after spike", 1'b0, ack);
    i_host.stop();
    exp_mem[10'h033] = d;
    wait_idle();
    chk("spiked byte", exp_mem[10'h033], mem[10'h033]);
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
      exp_mem[i] = mem[i];
    end
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    chk("idle drive", 1'b0, sda_oe_out);
    chk("drive level", 1'b0, sda_lvl);
    test_byte_poll();
    test_page();
    test_protect();
    test_read();
    test_bad_code();
    test_spike();
    summarize();
  end
endmodule
`default_nettype wire
